// ---- hdl/dagc_serial_gain_control.v ----
`timescale 1ns/100ps
`include "dagc_consts.vh"

// Behaviour
// - after reset every bit of the user configuration register is zero until a frame is accepted.
// - a complete frame commits on the first rising serial clock edge after the 16th falling edge or on chip select rising.
// - chip select rising before 16 falling serial clock edges flags an incomplete write and leaves the register alone.
// - new gain codes reach the amplifiers on the second falling edge of the internal sample clock after a commit.
// - only the gain fields wait for the sample clock; format, mode and bus select follow the commit at once.
// - the format bit sets both channels: zero gives unsigned binary, one gives two's complement.
// - each channel has its own 5-bit gain code selecting one of 32 steps from 0 dB to about 18 dB.
// - conversion runs on a 40 MHz internal sample clock whatever the applied clock option.
// - the applied clock is either 80 MHz, halved inside, or 40 MHz used directly.
// - samples leave on one shared bus or on two separate buses as the bus select bit says.
// - both channels are captured on the same sample clock edge as 10-bit words.
// - unsigned format maps full positive input to 3ff, zero input to 200 and full negative input to 000.
module dagc_serial_gain_control (
    // clock and reset
    input wire sys_clk,
    input wire reset_n,
    // serial control pins
    input wire serialClk,
    input wire serial_data_in,
    input wire chipSelect_n,
    // converter clock pin and clock option (1: 80 MHz applied, 0: 40 MHz applied)
    input wire sampleClkPin,
    input wire clockOption80,
    // raw unsigned converter codes of both channels
    input wire [`DAGC_DATA_W-1:0] rawCodeA,
    input wire [`DAGC_DATA_W-1:0] rawCodeB,
    // configuration as applied
    output reg [`DAGC_GAIN_W-1:0] gainCodeA,
    output reg [`DAGC_GAIN_W-1:0] gainCodeB,
    output wire output_signed_format,
    output wire modeBit,
    output wire bus_select_bit,
    output reg [15:0] userReg,
    // frame status
    output reg writeDone,
    output reg writeError,
    // converter clock and output buses
    output reg internal_sample_clock,
    output reg sampleTick,
    output reg [`DAGC_DATA_W-1:0] busAData,
    output reg [`DAGC_DATA_W-1:0] busBData,
    output reg busAIsChannelB
);

// ==========================================================
// helpers
function [`DAGC_DATA_W-1:0] formatCode;
    input [`DAGC_DATA_W-1:0] code;
    input signedFmt;
    begin
        // offset binary to two's complement is an msb flip
        formatCode = {code[`DAGC_DATA_MSB] ^ signedFmt, code[`DAGC_DATA_MSB-1:0]};
    end
endfunction

// ==========================================================
// pin synchronisers
wire sclkSync;
wire dataSync;
wire csSync;
wire clkSync;

dagc_pin_sync uSyncSclk (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .pinIn(serialClk),
    .pinOut(sclkSync)
);

dagc_pin_sync uSyncData (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .pinIn(serial_data_in),
    .pinOut(dataSync)
);

// chip select idles high; the synchroniser resets low, so a false rise is masked below
dagc_pin_sync uSyncCs (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .pinIn(chipSelect_n),
    .pinOut(csSync)
);

dagc_pin_sync uSyncClk (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .pinIn(sampleClkPin),
    .pinOut(clkSync)
);

reg sclkLast;
reg csLast;
reg clkLast;
reg csSeenHigh;

wire sclkFall = sclkLast & ~sclkSync;
wire sclkRise = ~sclkLast & sclkSync;
wire csRise = ~csLast & csSync & csSeenHigh;
wire clkRise = ~clkLast & clkSync;
wire clkFall = clkLast & ~clkSync;

always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
        sclkLast <= 1'b0;
        csLast <= 1'b0;
        clkLast <= 1'b0;
        csSeenHigh <= 1'b0;
    end else begin
        sclkLast <= sclkSync;
        csLast <= csSync;
        clkLast <= clkSync;
        if (csLast) begin
            csSeenHigh <= 1'b1;
        end
    end
end

// ==========================================================
// serial frame receiver
reg [15:0] shiftReg;
reg [`DAGC_CNT_W-1:0] bitCount;
reg frameFull;
reg frameDone;

wire frameActive = ~csSync & csSeenHigh;
wire commitBySclk = frameActive & frameFull & ~frameDone & sclkRise;
wire commitByCs = csRise & frameFull & ~frameDone;
wire commit = commitBySclk | commitByCs;

always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
        shiftReg <= `DAGC_REG_RESET;
        bitCount <= {`DAGC_CNT_W{1'b0}};
        frameFull <= 1'b0;
        frameDone <= 1'b0;
        userReg <= `DAGC_REG_RESET;
        writeDone <= 1'b0;
        writeError <= 1'b0;
    end else begin
        writeDone <= commit;
        writeError <= csRise & ~frameFull;
        if (commit) begin
            userReg <= shiftReg;
        end
        if (csSync) begin
            // a new frame starts clean; a short frame leaves userReg untouched
            bitCount <= {`DAGC_CNT_W{1'b0}};
            frameFull <= 1'b0;
            frameDone <= 1'b0;
        end else if (frameActive) begin
            if (commitBySclk) begin
                frameDone <= 1'b1;
            end
            // falling edges after the 16th are ignored until chip select rises
            if (sclkFall && !frameFull) begin
                shiftReg <= {shiftReg[14:0], dataSync};
                bitCount <= bitCount + 1'b1;
                if (bitCount == `DAGC_FRAME_BITS - 1) begin
                    frameFull <= 1'b1;
                end
            end
        end
    end
end

assign output_signed_format = userReg[`DAGC_BIT_SIGNED_FMT];
assign modeBit = userReg[`DAGC_BIT_MODE];
assign bus_select_bit = userReg[`DAGC_BIT_BUS_SEL];

// ==========================================================
// internal 40 MHz sample clock
wire intFall = clockOption80 ? (clkRise & internal_sample_clock) : clkFall;
wire intRise = clockOption80 ? (clkRise & ~internal_sample_clock) : clkRise;

always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
        internal_sample_clock <= 1'b0;
    end else if (clockOption80) begin
        // halving the 80 MHz clock keeps conversion at 40 MHz
        if (clkRise) begin
            internal_sample_clock <= ~internal_sample_clock;
        end
    end else begin
        internal_sample_clock <= clkSync;
    end
end

// ==========================================================
// gain resynchronisation; a later commit restarts the wait
reg [`DAGC_GAIN_W-1:0] pendingA;
reg [`DAGC_GAIN_W-1:0] pendingB;
reg gainPending;
reg [1:0] fallCount;

always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
        pendingA <= {`DAGC_GAIN_W{1'b0}};
        pendingB <= {`DAGC_GAIN_W{1'b0}};
        gainPending <= 1'b0;
        fallCount <= 2'h0;
        gainCodeA <= {`DAGC_GAIN_W{1'b0}};
        gainCodeB <= {`DAGC_GAIN_W{1'b0}};
    end else if (commit) begin
        pendingA <= shiftReg[`DAGC_GAIN_A_MSB:`DAGC_GAIN_A_LSB];
        pendingB <= shiftReg[`DAGC_GAIN_B_MSB:`DAGC_GAIN_B_LSB];
        gainPending <= 1'b1;
        fallCount <= 2'h0;
    end else if (gainPending && intFall) begin
        if (fallCount + 2'h1 == `DAGC_GAIN_APPLY_EDGES) begin
            // changing gain only at a sample edge avoids mid-sample glitches
            gainCodeA <= pendingA;
            gainCodeB <= pendingB;
            gainPending <= 1'b0;
            fallCount <= 2'h0;
        end else begin
            fallCount <= fallCount + 2'h1;
        end
    end
end

// ==========================================================
// sample capture and output buses
reg [`DAGC_DATA_W-1:0] heldB;

always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
        sampleTick <= 1'b0;
        heldB <= {`DAGC_DATA_W{1'b0}};
        busAData <= {`DAGC_DATA_W{1'b0}};
        busBData <= {`DAGC_DATA_W{1'b0}};
        busAIsChannelB <= 1'b0;
    end else begin
        sampleTick <= intFall;
        if (intFall) begin
            // both channels taken on the same edge
            heldB <= formatCode(rawCodeB, output_signed_format);
            busAData <= formatCode(rawCodeA, output_signed_format);
            busAIsChannelB <= 1'b0;
            if (bus_select_bit) begin
                busBData <= {`DAGC_DATA_W{1'b0}};
            end else begin
                busBData <= formatCode(rawCodeB, output_signed_format);
            end
        end else if (intRise && bus_select_bit) begin
            // shared bus: channel b follows in the second half of the sample period
            busAData <= heldB;
            busAIsChannelB <= 1'b1;
        end
    end
end

endmodule

// ---- shared/dagc_consts.vh ----
`ifndef DAGC_CONSTS_VH
`define DAGC_CONSTS_VH

// ==========================================================
// serial frame
`define DAGC_FRAME_BITS 16
`define DAGC_CNT_W 5
`define DAGC_REG_RESET 16'h0000

// ==========================================================
// field layout of the user configuration register
`define DAGC_GAIN_W 5
`define DAGC_GAIN_A_LSB 0
`define DAGC_GAIN_A_MSB 4
`define DAGC_GAIN_B_LSB 5
`define DAGC_GAIN_B_MSB 9
`define DAGC_BIT_SIGNED_FMT 10
`define DAGC_BIT_MODE 11
`define DAGC_BIT_BUS_SEL 12

// ==========================================================
// converter data
`define DAGC_DATA_W 10
`define DAGC_DATA_MSB 9

// ==========================================================
// timing
`define DAGC_GAIN_APPLY_EDGES 2'h2
`define DAGC_SYNC_STAGES 3

`endif

// ---- hdl/dagc_pin_sync.v ----
`timescale 1ns/100ps
`include "dagc_consts.vh"

// ==========================================================
// three-stage pin synchroniser; output moves once stages two and three agree
module dagc_pin_sync (
    // clock and reset
    input wire sys_clk,
    input wire reset_n,
    // pin side
    input wire pinIn,
    // synchronised side
    output reg pinOut
);

reg stage1;
reg stage2;
reg stage3;

always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
        stage1 <= 1'b0;
        stage2 <= 1'b0;
        stage3 <= 1'b0;
        pinOut <= 1'b0;
    end else begin
        stage1 <= pinIn;
        stage2 <= stage1;
        stage3 <= stage2;
        // stage1 is read by stage2 only
        if (stage2 == stage3) begin
            pinOut <= stage3;
        end
    end
end

endmodule

// ---- tb/dagc_monitor.sv ----
`timescale 1ns/100ps
// ==========================================
// port checker
module dagc_monitor (
    // clock and reset
    input wire sys_clk,
    input wire reset_n,
    // watched ports
    input wire [9:0] rawCodeA,
    input wire [4:0] gainCodeA,
    input wire [4:0] gainCodeB,
    input wire output_signed_format,
    input wire modeBit,
    input wire bus_select_bit,
    input wire [15:0] userReg,
    input wire writeDone,
    input wire writeError,
    input wire internal_sample_clock,
    input wire sampleTick,
    input wire [9:0] busAData,
    input wire [9:0] busBData
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    wire [9:0] gains = {gainCodeB, gainCodeA};
    sequence s_halfHold;
        $stable(internal_sample_clock)[*2];
    endsequence
    property p_regOnCommit; $changed(userReg) |-> writeDone; endproperty
    a_regOnCommit: assert property (p_regOnCommit) else $error("register moved without commit");
    property p_donePulse; writeDone |=> !writeDone; endproperty
    a_donePulse: assert property (p_donePulse) else $error("commit pulse too long");
    property p_errKeep; writeError |-> $stable(userReg) && !writeDone; endproperty
    a_errKeep: assert property (p_errKeep) else $error("aborted frame changed register");
    property p_gainWait; writeDone |=> $stable(gains)[*5]; endproperty
    a_gainWait: assert property (p_gainWait) else $error("gain applied too early");
    property p_gainApply; writeDone |-> ##[1:30] (gains == userReg[9:0]); endproperty
    a_gainApply: assert property (p_gainApply) else $error("gain not applied in time");
    property p_gainSource; $changed(gains) |-> gains == userReg[9:0]; endproperty
    a_gainSource: assert property (p_gainSource) else $error("gain not from register");
    property p_fields; {bus_select_bit, modeBit, output_signed_format} == userReg[12:10]; endproperty
    a_fields: assert property (p_fields) else $error("direct bits lag register");
    // each internal clock level must hold for three to eight system clock cycles
    property p_intClk;
        $changed(internal_sample_clock) |=> s_halfHold ##[1:6] $changed(internal_sample_clock);
    endproperty
    a_intClk: assert property (p_intClk) else $error("internal clock rate wrong");
    // cycles around a commit are skipped: the format may legally switch mid-sample
    property p_busA;
        sampleTick && !writeDone && !$past(writeDone) && !$past(writeDone, 2)
            |-> busAData == {rawCodeA[9] ^ output_signed_format, rawCodeA[8:0]};
    endproperty
    a_busA: assert property (p_busA) else $error("bus a data wrong");
    // a sample taken just before the commit still carries the old bus layout
    property p_busB;
        sampleTick && bus_select_bit && !writeDone && !$past(writeDone) |-> busBData == 10'h000;
    endproperty
    a_busB: assert property (p_busB) else $error("bus b not idle in shared mode");
endmodule

// ---- tb/dagc_host_model.sv ----
`timescale 1ns/100ps
// ==========================================
// host controller: serial writes and applied converter clock
module dagc_host_model (
    // timing reference
    input wire sys_clk,
    // pins at the device
    output logic serialClk,
    output logic serial_data_in,
    output logic chipSelect_n,
    output logic sampleClkPin
);
    // no pulls on these pins, so all are driven from time zero
    initial begin
        serialClk = 1'b1;
        serial_data_in = 1'b0;
        chipSelect_n = 1'b1;
        sampleClkPin = 1'b0;
    end
    // applied clock, slowed so that every level spans three system clock samples
    int clkPhase = 0;
    always @(posedge sys_clk) begin
        if (clkPhase == 2) begin
            clkPhase <= 0;
            sampleClkPin <= ~sampleClkPin;
        end else begin
            clkPhase <= clkPhase + 1;
        end
    end
    task automatic waitClk(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    // msb first; endOnCs leaves the last rise to chip select
    task automatic send(input logic [15:0] word, input int nFall, input bit endOnCs);
        chipSelect_n <= 1'b0;
        for (int i = 0; i < nFall; i++) begin
            serial_data_in <= word[15 - i];
            waitClk(10);
            serialClk <= 1'b0;
            waitClk(10);
            if (!(endOnCs && i == nFall - 1)) begin
                serialClk <= 1'b1;
            end
        end
        waitClk(10);
        chipSelect_n <= 1'b1;
        serial_data_in <= ~serial_data_in;
        waitClk(10);
        serialClk <= 1'b1;
        waitClk(10);
    endtask
endmodule

// ---- tb/tb_top.sv ----
`timescale 1ns/100ps
// ==========================================
// top bench
module tb_top;
    logic sys_clk;
    logic reset_n;
    logic clockOption80;
    logic [9:0] rawCodeA;
    logic [9:0] rawCodeB;
    wire serialClk, serial_data_in, chipSelect_n, sampleClkPin;
    wire [4:0] gainCodeA, gainCodeB;
    wire output_signed_format, modeBit, bus_select_bit, writeDone, writeError, internal_sample_clock, sampleTick;
    wire busAIsChannelB;
    wire [15:0] userReg;
    wire [9:0] busAData, busBData;
    int numErrors = 0;
    int numChecks = 0;
    int cycles = 0;
    bit sawError = 0;
    logic [15:0] words [4] = '{16'h0421, 16'h03e0, 16'h1fff, 16'h0c63};
    dagc_host_model host_u (.sys_clk(sys_clk), .serialClk(serialClk), .serial_data_in(serial_data_in),
        .chipSelect_n(chipSelect_n), .sampleClkPin(sampleClkPin));
    dagc_serial_gain_control dut_u (.sys_clk(sys_clk), .reset_n(reset_n), .serialClk(serialClk),
        .serial_data_in(serial_data_in), .chipSelect_n(chipSelect_n), .sampleClkPin(sampleClkPin),
        .clockOption80(clockOption80), .rawCodeA(rawCodeA), .rawCodeB(rawCodeB), .gainCodeA(gainCodeA),
        .gainCodeB(gainCodeB), .output_signed_format(output_signed_format), .modeBit(modeBit),
        .bus_select_bit(bus_select_bit), .userReg(userReg), .writeDone(writeDone), .writeError(writeError),
        .internal_sample_clock(internal_sample_clock), .sampleTick(sampleTick), .busAData(busAData),
        .busBData(busBData), .busAIsChannelB(busAIsChannelB));
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        numChecks++;
        if (got !== exp) begin
            numErrors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    task automatic give_verdict;
        if (numErrors == 0 && numChecks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // a hang counts as a mismatch
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (writeError === 1'b1) begin
            sawError <= 1'b1;
        end
        if (cycles == 4000) begin
            numErrors++;
            give_verdict();
        end
    end
    initial begin
        reset_n = 1'b0;
        clockOption80 = 1'b1;
        rawCodeA = 10'h200;
        rawCodeB = 10'h3ff;
        repeat (10) @(posedge sys_clk);
        reset_n <= 1'b1;
        repeat (10) @(posedge sys_clk);
        check("userReg", 16'h0000, userReg);
        check("gains", 10'h000, {gainCodeB, gainCodeA});
        for (int k = 0; k < 4; k++) begin
            if (k == 3) begin
                check("writeError", 1'b0, sawError);
                host_u.send(16'h0000, 5, 1'b0);
                check("userReg", 16'h1fff, userReg);
                check("writeError", 1'b1, sawError);
                // second reset in mid-run, then the applied clock is used directly
                reset_n <= 1'b0;
                clockOption80 <= 1'b0;
                repeat (10) @(posedge sys_clk);
                reset_n <= 1'b1;
                repeat (10) @(posedge sys_clk);
                check("userReg", 16'h0000, userReg);
                check("gains", 10'h000, {gainCodeB, gainCodeA});
            end
            host_u.send(words[k], 16, k == 1);
            check("userReg", words[k], userReg);
            check("fields", words[k][12:10], {bus_select_bit, modeBit, output_signed_format});
            repeat (30) @(posedge sys_clk);
            check("gains", words[k][9:0], {gainCodeB, gainCodeA});
            for (int n = 0; n < 20 && sampleTick !== 1'b1; n++) @(negedge sys_clk);
            check("sampleTick", 1'b1, sampleTick);
            check("busAData", {rawCodeA[9] ^ words[k][10], rawCodeA[8:0]}, busAData);
            check("busBData", words[k][12] ? 10'h000 : {rawCodeB[9] ^ words[k][10], rawCodeB[8:0]}, busBData);
            if (words[k][12]) begin
                for (int n = 0; n < 20 && busAIsChannelB !== 1'b1; n++) @(negedge sys_clk);
                check("busAIsChannelB", 1'b1, busAIsChannelB);
                check("busAShared", {rawCodeB[9] ^ words[k][10], rawCodeB[8:0]}, busAData);
            end
            @(posedge sys_clk);
        end
        give_verdict();
    end
endmodule
bind dagc_serial_gain_control dagc_monitor mon_u (.sys_clk(sys_clk), .reset_n(reset_n), .rawCodeA(rawCodeA),
    .gainCodeA(gainCodeA), .gainCodeB(gainCodeB), .output_signed_format(output_signed_format),
    .modeBit(modeBit), .bus_select_bit(bus_select_bit), .userReg(userReg), .writeDone(writeDone),
    .writeError(writeError), .internal_sample_clock(internal_sample_clock), .sampleTick(sampleTick),
    .busAData(busAData), .busBData(busBData));
